// ---- logic/pdl_cfg.svh ----
`ifndef PDL_CFG_SVH
`define PDL_CFG_SVH
// sizes of the cell array and the configuration store
`define PDL_NCELL 8
`define PDL_NWORD 16
`define PDL_AW 4
`define PDL_DW 16
`define PDL_FRAME_BITS 5'h18
`define PDL_OPT_ADDR 4'h8
// power-down pins share the top two cells
`define PDL_PDA_CELL 6
`define PDL_PDB_CELL 7
`define PDL_PD_MASK 8'hC0
// settling window after power-up reset
`define PDL_CLK_NS 20
`define PDL_TD_NS 100
`define PDL_SETTLE_CYC ((`PDL_TD_NS + `PDL_CLK_NS - 1) / `PDL_CLK_NS)
`define PDL_SET_W 3
// supply trip levels in millivolts
`define PDL_TRIP_HI_MV 12'hAF0
`define PDL_TRIP_LO_MV 12'h2BC
`endif

// ---- logic/pdl_pkg.sv ----
`include "pdl_cfg.svh"
package pdl_pkg;
   // programming frame commands
   typedef enum logic [3:0] {
      CMD_NOP    = 4'h0,
      CMD_WRITE  = 4'h1,
      CMD_READ   = 4'h2,
      CMD_SIG_WR = 4'h3,
      CMD_SIG_RD = 4'h4,
      CMD_FUSE   = 4'h5,
      CMD_ERASE  = 4'h6
   } pdl_cmd_t;
   typedef struct packed {
      pdl_cmd_t             cmd;
      logic [`PDL_AW-1:0]   addr;
      logic [`PDL_DW-1:0]   data;
   } pdl_frame_t;
   // per-cell configuration word
   typedef struct packed {
      logic [11:0] rsvd;
      logic        fast;
      logic        rpwr;
      logic        oe;
      logic        inv;
   } pdl_cell_cfg_t;
   // global option word, erased value is all defaults
   typedef struct packed {
      logic [10:0] rsvd;
      logic        jtag_off;
      logic        keep;
      logic        pwr_rst_off;
      logic        stby_en;
      logic        pd_en;
   } pdl_opt_t;
   typedef struct packed {
      logic                  tck;
      logic                  tms;
      logic                  tdi;
      logic [`PDL_NCELL-1:0] drv;
      logic [`PDL_NCELL-1:0] pin;
   } pdl_sync_t;
   typedef struct packed {
      logic pwr_down;
      logic standby;
      logic locked;
      logic fuse;
      logic jtag_off;
   } pdl_stat_t;
endpackage

// ---- logic/pdl_top.sv ----
// Notes on behaviour
// - either power-down pin high powers down
// - power down holds cell state and pad outputs
// - pin transitions ignored by cells and serial port while powered down
// - power-down pins are not logic I/O
// - optional standby when nothing toggles
// - per-cell reduced power setting
// - per-output slew, slow by default
// - power-reset option on, selects trip level
// - power-up reset clears every register, except the pad enables, which reset to float
// - fuse blocks configuration readback
// - user signature always readable
// - programming over four-pin serial port
// - serial port can be released as I/O
// - interrupted programming locks, pins float
// - keeper holds pins during programming
// - device starts out erased
// - keeper holds floating pins at level
`timescale 1ns/10ps
`default_nettype none
`include "pdl_cfg.svh"
module pdl_top
   import pdl_pkg::*;
(
   input  wire logic                  CLK,      // 50 MHz
   input  wire logic                  RST,      // async, high
   input  wire logic [`PDL_NCELL-1:0] PIN_I,    // pad levels
   input  wire logic [`PDL_NCELL-1:0] PIN_DRV,  // pad driven outside
   output logic      [`PDL_NCELL-1:0] PIN_O,    // pad drive value
   output logic      [`PDL_NCELL-1:0] PIN_OE_N, // low drives pad
   output logic      [`PDL_NCELL-1:0] PIN_FAST, // fast slew
   output logic      [`PDL_NCELL-1:0] PIN_RPWR, // reduced power
   input  wire logic                  TCK,      // serial clock
   input  wire logic                  TMS,      // frame select
   input  wire logic                  TDI,      // serial in
   output logic                       TDO_O,    // serial out
   output logic                       TDO_OE_N, // low drives
   output logic      [2:0]            JPIN_O,   // released pins
   output logic      [11:0]           TRIP_MV,  // trip level
   output pdl_stat_t                  STAT      // status flags
);
   localparam logic [`PDL_SET_W-1:0] SETTLE =
      `PDL_SET_W'(`PDL_SETTLE_CYC);

   pdl_sync_t                  s1_q, s2_q;
   logic                       tck_p_q, tms_p_q;
   logic [`PDL_DW-1:0]         mem_q [`PDL_NWORD];
   logic [`PDL_DW-1:0]         sig_q, shout_q;
   logic [23:0]                sh_q;
   logic [4:0]                 bcnt_q;
   logic                       fuse_q, locked_q, phase_q;
   logic [`PDL_SET_W-1:0]      set_q;
   logic [`PDL_NCELL-1:0]      cell_q, cell_d, last_q;
   logic [`PDL_NCELL-1:0]      oe_n_q, oe_n_d;
   logic [`PDL_NCELL-1:0]      fast_q, rp_q;
   logic [11:0]                trip_q;
   pdl_stat_t                  stat_q;
   pdl_opt_t                   opt;
   pdl_frame_t                 fr;
   pdl_cell_cfg_t              ccfg [`PDL_NCELL];
   logic [`PDL_NCELL-1:0]      pin_eff, src, nxt, upd, pd_mask;
   logic [`PDL_NCELL-1:0]      inv_v, oe_v, rp_v, fast_v;
   logic                       pd_active, jt_live, tck_rise;
   logic                       frame, frame_end, exec, abort;
   logic                       settled, run, hold_pins, trans;
   logic                       float_all;

   // two flops on every pad and serial pin
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         s1_q    <= '0;
         s2_q    <= '0;
         tck_p_q <= 1'b0;
         tms_p_q <= 1'b0;
      end
      else
      begin
         s1_q    <= {TCK, TMS, TDI, PIN_DRV, PIN_I};
         s2_q    <= s1_q;
         tck_p_q <= s2_q.tck;
         tms_p_q <= s2_q.tms;
      end
   end

   // option and cell configuration decode
   assign opt = pdl_opt_t'(mem_q[`PDL_OPT_ADDR]);
   assign fr  = pdl_frame_t'(sh_q);
   for (genvar i = 0; i < `PDL_NCELL; i++)
   begin : g_cell
      assign ccfg[i]   = pdl_cell_cfg_t'(mem_q[i]);
      assign inv_v[i]  = ccfg[i].inv;
      assign oe_v[i]   = ccfg[i].oe;
      assign rp_v[i]   = ccfg[i].rpwr;
      assign fast_v[i] = ccfg[i].fast;
      // a power-down pin's cell runs on buried cascade only
      assign src[i] = pd_mask[i] ?
         cell_q[(i + `PDL_NCELL - 1) % `PDL_NCELL] : pin_eff[i];
   end

   // power-down request from either pin
   assign pd_mask   = opt.pd_en ? `PDL_PD_MASK : '0;
   assign pd_active = opt.pd_en &
      (s2_q.pin[`PDL_PDA_CELL] | s2_q.pin[`PDL_PDB_CELL]);

   // keeper: an undriven pad reads its last level
   assign pin_eff = opt.keep ?
      ((s2_q.drv & s2_q.pin) | (~s2_q.drv & last_q)) : s2_q.pin;
   assign trans   = |(pin_eff ^ last_q);

   // serial port framing, dead while powered down or released
   assign jt_live   = ~opt.jtag_off & ~pd_active;
   assign tck_rise  = jt_live & s2_q.tck & ~tck_p_q;
   assign frame     = jt_live & s2_q.tms;
   assign frame_end = jt_live & tms_p_q & ~s2_q.tms;
   assign exec      = frame_end & (bcnt_q == `PDL_FRAME_BITS);
   assign abort     = frame_end & (bcnt_q != `PDL_FRAME_BITS) &
                      (bcnt_q != 5'h0);

   // frame shift register and bit count
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sh_q   <= '0;
         bcnt_q <= '0;
      end
      else
      begin
         if (tck_rise & frame)
            sh_q <= {sh_q[22:0], s2_q.tdi};
         if (~frame)
            bcnt_q <= '0;
         else if (tck_rise & (bcnt_q != 5'h1F))
            bcnt_q <= bcnt_q + 5'h1;
      end
   end

   // configuration store, fuse and signature
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         for (int k = 0; k < `PDL_NWORD; k++)
            mem_q[k] <= '0;
         fuse_q <= 1'b0;
         sig_q  <= '0;
      end
      else if (exec)
      begin
         unique case (fr.cmd)
            CMD_WRITE:  mem_q[fr.addr] <= fr.data;
            CMD_SIG_WR: sig_q <= fr.data;
            CMD_FUSE:   fuse_q <= 1'b1;
            CMD_ERASE:
            begin
               for (int k = 0; k < `PDL_NWORD; k++)
                  mem_q[k] <= '0;
               fuse_q <= 1'b0;
            end
            default: ;
         endcase
      end
   end

   // readback word, shifted out msb first
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         shout_q <= '0;
      else if (exec & (fr.cmd == CMD_READ))
         shout_q <= fuse_q ? '0 : mem_q[fr.addr];
      else if (exec & (fr.cmd == CMD_SIG_RD))
         shout_q <= sig_q;
      else if (tck_rise & frame)
         shout_q <= {shout_q[`PDL_DW-2:0], 1'b0};
   end

   // lock stays until a whole frame lands; abort wins
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         locked_q <= 1'b0;
      else if (abort)
         locked_q <= 1'b1;
      else if (exec)
         locked_q <= 1'b0;
   end

   // settling window after reset before cells may move
   assign settled = (set_q == SETTLE);
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         set_q   <= '0;
         phase_q <= 1'b0;
      end
      else
      begin
         if (~settled)
            set_q <= set_q + `PDL_SET_W'(1);
         phase_q <= ~phase_q;
      end
   end

   // cells move only when nothing freezes them
   assign run  = ~pd_active & settled & ~frame & ~locked_q;
   // reduced-power cells step every other cycle, trading speed
   assign upd  = {`PDL_NCELL{run}} & (~rp_v | {`PDL_NCELL{phase_q}});
   assign nxt  = src ^ inv_v;
   assign cell_d = (upd & nxt) | (~upd & cell_q);

   // pad enables: float on lock or a frame without keeper, hold in power down or a kept frame
   assign hold_pins = pd_active | (frame & opt.keep);
   assign float_all = locked_q | (frame & ~opt.keep);
   assign oe_n_d = float_all ? '1 :
                   hold_pins ? oe_n_q : (~oe_v | pd_mask);

   // cell state, keeper memory, enables and pad options
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         cell_q <= '0;
         last_q <= '0;
         oe_n_q <= '1;
         fast_q <= '0;
         rp_q   <= '0;
      end
      else
      begin
         cell_q <= cell_d;
         if (~pd_active)
            last_q <= pin_eff;
         oe_n_q <= oe_n_d;
         fast_q <= fast_v;
         rp_q   <= rp_v;
      end
   end

   // status and trip level, refreshed every cycle
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         stat_q <= '0;
         trip_q <= '0;
      end
      else
      begin
         stat_q.pwr_down <= pd_active;
         stat_q.standby  <= opt.stby_en & ~trans;
         stat_q.locked   <= locked_q;
         stat_q.fuse     <= fuse_q;
         stat_q.jtag_off <= opt.jtag_off;
         trip_q <= opt.pwr_rst_off ?
            `PDL_TRIP_LO_MV : `PDL_TRIP_HI_MV;
      end
   end

   // released serial pins act as plain logic
   assign PIN_O    = cell_q;
   assign PIN_OE_N = oe_n_q;
   assign PIN_FAST = fast_q;
   assign PIN_RPWR = rp_q;
   assign TDO_O    = opt.jtag_off ? cell_q[0] : shout_q[`PDL_DW-1];
   assign TDO_OE_N = opt.jtag_off ? oe_n_q[0] : ~frame;
   assign JPIN_O   = opt.jtag_off ?
      {s2_q.tck, s2_q.tms, s2_q.tdi} : 3'h0;
   assign TRIP_MV  = trip_q;
   assign STAT     = stat_q;

   default clocking dcb @(posedge CLK);
   endclocking
   default disable iff (RST);

   pd_status_a: assert property (
      opt.pd_en && (s2_q.pin[`PDL_PDA_CELL] || s2_q.pin[`PDL_PDB_CELL])
      |=> STAT.pwr_down)
      else $error("power down not reported");
   pd_hold_a: assert property (
      pd_active |=> $stable(cell_q) && $stable(PIN_OE_N))
      else $error("state moved during power down");
   pd_ignore_a: assert property (
      pd_active |-> !exec && !abort)
      else $error("serial frame taken during power down");
   pd_pin_a: assert property (
      opt.pd_en && !hold_pins && !float_all
      |=> PIN_OE_N[`PDL_PDA_CELL] && PIN_OE_N[`PDL_PDB_CELL])
      else $error("power-down pin driven as output");
   standby_a: assert property (
      opt.stby_en && !trans |=> STAT.standby)
      else $error("standby not entered");
   rpwr_step_a: assert property (
      ccfg[0].rpwr && !phase_q |=> cell_q[0] == $past(cell_q[0]))
      else $error("reduced-power cell stepped off phase");
   slew_map_a: assert property (
      ##1 PIN_FAST == $past(fast_v))
      else $error("slew select mismatch");
   // the edge that releases reset still shows the cleared trip level
   trip_sel_a: assert property (
      !opt.pwr_rst_off && !$past(RST) |=> TRIP_MV == `PDL_TRIP_HI_MV)
      else $error("trip level wrong with option on");
   trip_low_a: assert property (
      opt.pwr_rst_off |=> TRIP_MV == `PDL_TRIP_LO_MV)
      else $error("trip level wrong with option off");
   settle_wait_a: assert property (
      !settled |=> cell_q == $past(cell_q))
      else $error("cells moved inside settling window");
   fuse_block_a: assert property (
      exec && fr.cmd == CMD_READ && fuse_q |=> shout_q == '0)
      else $error("readback with fuse set");
   sig_read_a: assert property (
      exec && fr.cmd == CMD_SIG_RD |=> shout_q == $past(sig_q))
      else $error("signature not returned");
   lock_float_a: assert property (
      abort |=> locked_q ##1 (PIN_OE_N == '1))
      else $error("pins driven after interrupted frame");
   keep_hold_a: assert property (
      frame && opt.keep |=> $stable(PIN_O))
      else $error("pin level lost during programming");
   resume_a: assert property (
      $fell(pd_active) |-> cell_q == $past(cell_q))
      else $error("state lost leaving power down");
   standby_off_a: assert property (
      trans |=> !STAT.standby)
      else $error("standby shown while pins toggle");
   erase_clear_a: assert property (
      exec && fr.cmd == CMD_ERASE |=> !fuse_q && opt == '0 && $stable(sig_q))
      else $error("erase left configuration behind");
   port_rel_a: assert property (
      opt.jtag_off |-> !frame && !exec)
      else $error("released port still takes frames");
   lock_keep_a: assert property (
      locked_q && !exec |=> locked_q)
      else $error("lock dropped without a good frame");
   tdo_drive_a: assert property (
      frame |-> !TDO_OE_N)
      else $error("serial out not driven in frame");
endmodule // pdl_top
`default_nettype wire

// ---- bench/pdl_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pdl_cfg.svh"
// far side: pad drivers and the serial programmer
module pdl_host
   import pdl_pkg::*;
(
   input  wire logic                  CLK,      // clock
   input  wire logic [`PDL_NCELL-1:0] PIN_O,    // device value
   input  wire logic [`PDL_NCELL-1:0] PIN_OE_N, // low drives
   input  wire logic                  TDO_O,    // serial out
   output logic      [`PDL_NCELL-1:0] PIN_I,    // pad level
   output logic      [`PDL_NCELL-1:0] PIN_DRV,  // we drive pad
   output logic                       TCK,      // serial clock
   output logic                       TMS,      // frame select
   output logic                       TDI       // serial in
);
   logic [`PDL_NCELL-1:0] ext_v;
   logic [`PDL_NCELL-1:0] last_q;
   // idle serial pins; nothing toggles until the bench asks
   initial
   begin
      TCK = 1'b0;
      TMS = 1'b0;
      TDI = 1'b0;
      ext_v = '0;
      PIN_DRV = '1;
   end
   // a pad nobody drives shows the inverse of its last level
   assign PIN_I = (~PIN_OE_N & PIN_O) | (PIN_OE_N & PIN_DRV & ext_v)
                | (PIN_OE_N & ~PIN_DRV & ~last_q);
   always_ff @(posedge CLK)
      last_q <= PIN_I;
   // one frame on the four-pin port, n bits, up to 16 bits read back
   task automatic frame(input logic [23:0] f, input int n,
                        output logic [15:0] rd);
      rd = '0;
      @(posedge CLK) TMS <= 1'b1;
      repeat (4) @(posedge CLK);
      for (int i = 0; i < n; i++)
      begin
         if (i < 16)
            rd = {rd[14:0], TDO_O};
         TDI <= f[23-i];
         repeat (4) @(posedge CLK);
         TCK <= 1'b1;
         repeat (4) @(posedge CLK);
         TCK <= 1'b0;
      end
      repeat (4) @(posedge CLK);
      TMS <= 1'b0;
      repeat (8) @(posedge CLK);
   endtask
endmodule // pdl_host
`default_nettype wire

// ---- bench/pdl_top_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pdl_cfg.svh"
module pdl_top_test
   import pdl_pkg::*;
;
   logic clk, rst, tck, tms, tdi, tdo_o, tdo_oe_n;
   logic [7:0] pin_i, pin_drv, pin_o, pin_oe_n, pin_fast, pin_rpwr;
   logic [2:0] jpin_o;
   logic [11:0] trip_mv;
   logic [15:0] rd;
   pdl_stat_t stat;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   pdl_top i_dut (.CLK(clk), .RST(rst), .PIN_I(pin_i),
      .PIN_DRV(pin_drv), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n),
      .PIN_FAST(pin_fast), .PIN_RPWR(pin_rpwr), .TCK(tck),
      .TMS(tms), .TDI(tdi), .TDO_O(tdo_o), .TDO_OE_N(tdo_oe_n),
      .JPIN_O(jpin_o), .TRIP_MV(trip_mv), .STAT(stat));
   pdl_host i_host (.CLK(clk), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n),
      .TDO_O(tdo_o), .PIN_I(pin_i), .PIN_DRV(pin_drv), .TCK(tck),
      .TMS(tms), .TDI(tdi));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", mismatches, total_checks);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard, well above the expected few thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] got, exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m,
                  got, exp);
      end
   endtask
   task automatic cmd(input pdl_cmd_t c, input logic [3:0] a,
                      input logic [15:0] d);
      i_host.frame({c, a, d}, 24, rd);
   endtask
   // next frame shifts out the previous result
   task automatic rdback(output logic [15:0] v);
      i_host.frame(24'h00_0000, 24, v);
   endtask
   task automatic pad(input int i, input logic v);
      @(posedge clk) i_host.ext_v[i] <= v;
      repeat (10) @(posedge clk);
   endtask
   initial
   begin
      rst = 1'b1;
      repeat (20) @(posedge clk);
      chk(pin_oe_n, 16'h00FF, "oe in reset");
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk(trip_mv, 16'h0AF0, "trip");
      chk(pin_fast, 16'h0000, "slew");
      chk(pin_o, 16'h0000, "cells");
      chk(stat.fuse, 16'h0000, "fuse");
      chk(tdo_oe_n, 16'h0001, "tdo idle");
      // cell 0 drives its pad and feeds on it, so the host keeps
      // that pad low while it floats: junk there would circulate
      cmd(CMD_WRITE, 4'h0, 16'h000E);
      chk(pin_oe_n[0], 16'h0000, "oe");
      chk({pin_fast, pin_rpwr}, 16'h0101, "fast rpwr");
      pad(1, 1'b1);
      chk(pin_o[1], 16'h0001, "follow");
      // power down through the first pin
      cmd(CMD_WRITE, 4'h8, 16'h0001);
      pad(6, 1'b1);
      chk(stat.pwr_down, 16'h0001, "pd");
      chk(pin_o[6], 16'h0000, "pd pin");
      pad(1, 1'b0);
      chk(pin_o[1], 16'h0001, "held");
      chk(pin_oe_n[0], 16'h0000, "oe held");
      pad(6, 1'b0);
      chk(stat.pwr_down, 16'h0000, "pd off");
      chk(pin_o[1], 16'h0000, "resume");
      cmd(CMD_WRITE, 4'h8, 16'h0006);
      chk(trip_mv, 16'h02BC, "trip low");
      repeat (20) @(posedge clk);
      chk(stat.standby, 16'h0001, "standby");
      // readback, signature, then the fuse
      cmd(CMD_READ, 4'h0, 16'h0000);
      rdback(rd);
      chk(rd, 16'h000E, "read");
      cmd(CMD_SIG_WR, 4'h0, 16'hA5C3);
      cmd(CMD_FUSE, 4'h0, 16'h0000);
      chk(stat.fuse, 16'h0001, "fuse set");
      cmd(CMD_READ, 4'h0, 16'h0000);
      rdback(rd);
      chk(rd, 16'h0000, "read locked");
      cmd(CMD_SIG_RD, 4'h0, 16'h0000);
      rdback(rd);
      chk(rd, 16'hA5C3, "signature");
      // aborted frame locks and floats every pad
      i_host.frame(24'h10_0000, 10, rd);
      chk(stat.locked, 16'h0001, "lock");
      chk(pin_oe_n, 16'h00FF, "float");
      cmd(CMD_WRITE, 4'h8, 16'h0008);
      chk(stat.locked, 16'h0000, "unlock");
      pad(1, 1'b1);
      @(posedge clk) i_host.PIN_DRV[1] <= 1'b0;
      repeat (10) @(posedge clk);
      chk(pin_o[1], 16'h0001, "keeper");
      cmd(CMD_SIG_WR, 4'h0, 16'h3C5A);
      chk(pin_o[1], 16'h0001, "keep prog");
      cmd(CMD_ERASE, 4'h0, 16'h0000);
      chk(stat.fuse, 16'h0000, "erased");
      // release the serial port as plain pins
      cmd(CMD_WRITE, 4'h8, 16'h0010);
      chk(stat.jtag_off, 16'h0001, "port off");
      @(posedge clk) i_host.TDI <= 1'b1;
      i_host.TCK <= 1'b1;
      repeat (6) @(posedge clk);
      // pins come back as {clock, select, data}
      chk(jpin_o, 16'h0005, "jpins");
      chk(tdo_o, 16'h0000, "tdo as pin");
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk({stat.jtag_off, trip_mv}, 16'h0AF0, "erased again");
      end_of_test();
   end
endmodule // pdl_top_test
`default_nettype wire
